//--- core/pcixb_pkg.sv
// constants for the split budget and power capability registers
// assumes byte offsets within configuration space, dword aligned
package pcixb_pkg;
  localparam logic [7:0]  UP_SPLIT_OFS      = 8'h88;
  localparam logic [7:0]  DN_SPLIT_OFS      = 8'h8C;
  localparam logic [7:0]  PM_CAP_OFS        = 8'h90;
  localparam int          CAP_LSB           = 0;
  localparam int          LIMIT_LSB         = 16;
  localparam logic [15:0] SPLIT_CAP_ADQ     = 16'h0010;
  localparam logic [15:0] LIMIT_RESET       = 16'h0010;
  localparam logic [15:0] LIMIT_UNBOUNDED   = 16'hFFFF;
  localparam logic [7:0]  PM_ID             = 8'h01;
  localparam logic [7:0]  PM_NEXT           = 8'hA8;
  localparam logic [2:0]  PM_VERSION        = 3'h2;
  localparam logic        PM_CLOCK_NEEDED   = 1'h0;
  localparam logic        PM_RESERVED20     = 1'h0;
  localparam logic        PM_DSI            = 1'h0;
  localparam logic [2:0]  PM_AUX_CURRENT    = 3'h1;
  localparam logic        PM_D1_SUPPORT     = 1'h0;
  localparam logic        PM_D2_SUPPORT     = 1'h0;
  localparam logic [4:0]  PM_WAKE_SUPPORT   = 5'h19;
  localparam logic [15:0] PM_FEATURES = {PM_WAKE_SUPPORT, PM_D2_SUPPORT, PM_D1_SUPPORT,
                                         PM_AUX_CURRENT, PM_DSI, PM_RESERVED20,
                                         PM_CLOCK_NEEDED, PM_VERSION};
  localparam logic [31:0] PM_CAP_WORD = {PM_FEATURES, PM_NEXT, PM_ID};
endpackage

//--- core/pcixb_cap_regs.sv
// split budget registers, split request throttling and power capability header
// assumes configuration reads and writes come from logic on ref_clk, one per cycle
// How it works
// - the upstream capability half reads 0010h and ignores writes.
// - the downstream capability half reads 0010h and ignores writes.
// - the upstream limit in bits 31:16 is writable and resets to 0010h.
// - the downstream limit in bits 31:16 is writable and resets to 0010h.
// - any limit value is kept, and FFFFh lets every split request through unchecked.
// - a request that does not fit the room left is held back and a sticky flag is set.
// - the power capability identifier reads 01h.
// - the next pointer reads A8h.
// - the version field reads 010.
// - the wake clock bit reads zero.
// - the special initialisation bit reads zero.
// - the D1 support bit reads zero.
// - the D2 support bit reads zero.
// - the wake support field reads 11001.
`timescale 1ns/10ps

module pcixb_split_gate (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] limit,
  input  wire logic        req_valid,
  input  wire logic [15:0] req_adq,
  input  wire logic        cmpl_valid,
  input  wire logic [15:0] cmpl_adq,
  input  wire logic        delay_clr,
  output logic             req_fwd,
  output logic             delayed
);
  import pcixb_pkg::*;

  logic [15:0] owed;
  logic [15:0] next_owed;
  logic        next_fwd;
  logic        next_delayed;
  logic [16:0] want;
  logic [17:0] sum;
  logic        unbounded;
  logic        fits;
  logic        take;

  always_comb begin
    unbounded = (limit == LIMIT_UNBOUNDED);
    want      = {1'b0, owed} + {1'b0, req_adq};
    fits      = (want <= {1'b0, limit});
    // owed still counts under an unbounded limit, so a tighter limit sees the backlog
    // unbounded bypass
    take      = req_valid && !req_fwd && (unbounded || fits);
    next_fwd  = take;
    // sticky delay flag, set beats clear
    next_delayed = (req_valid && !req_fwd && !take) || (delayed && !delay_clr);
    // owed saturates so an unbounded burst cannot wrap the count
    sum = {2'b00, owed} + (take ? {2'b00, req_adq} : 18'h00000)
          - (cmpl_valid ? {2'b00, cmpl_adq} : 18'h00000);
    if (sum[17]) begin
      next_owed = 16'h0000;
    end else if (sum[16]) begin
      next_owed = 16'hFFFF;
    end else begin
      next_owed = sum[15:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      owed    <= 16'h0000;
      req_fwd <= 1'b0;
      delayed <= 1'b0;
    end else begin
      owed    <= next_owed;
      req_fwd <= next_fwd;
      delayed <= next_delayed;
    end
  end

  a_fit_forwards: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid && !req_fwd && fits |=> req_fwd)
    else $error("fitting split request not forwarded");
  a_over_delays: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid && !req_fwd && !fits && !unbounded |=> !req_fwd && delayed)
    else $error("oversize split request not delayed");
  a_unbound_pass: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid && !req_fwd && limit == LIMIT_UNBOUNDED |=> req_fwd ##1 !req_fwd)
    else $error("unbounded limit did not forward");
  a_delay_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    delayed && !delay_clr |=> delayed)
    else $error("delay flag dropped without clear");
  a_gate_reset: assert property (@(posedge ref_clk)
    rst |=> !req_fwd && !delayed && owed == 16'h0000)
    else $error("split gate not idle after reset");
  a_fwd_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    req_fwd |=> !req_fwd)
    else $error("forward pulse longer than one cycle");
  a_fwd_needs_req: assert property (@(posedge ref_clk) disable iff (rst)
    !req_valid |=> !req_fwd)
    else $error("forward without a pending request");
  a_delay_clears: assert property (@(posedge ref_clk) disable iff (rst)
    delay_clr && !(req_valid && !req_fwd && !fits && !unbounded) |=> !delayed)
    else $error("delay flag not cleared");
  a_delay_cause: assert property (@(posedge ref_clk) disable iff (rst)
    !delayed && !(req_valid && !req_fwd && !fits && !unbounded) |=> !delayed)
    else $error("delay flag set without a held request");
  a_owed_adds: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid && !req_fwd && fits && !unbounded && !cmpl_valid
    |=> owed == $past(owed) + $past(req_adq))
    else $error("forwarded size not added to owed");
  a_owed_drains: assert property (@(posedge ref_clk) disable iff (rst)
    cmpl_valid && !(req_valid && !req_fwd) && cmpl_adq <= owed
    |=> owed == $past(owed) - $past(cmpl_adq))
    else $error("completion not drained from owed");
  a_owed_floor: assert property (@(posedge ref_clk) disable iff (rst)
    cmpl_valid && !(req_valid && !req_fwd) && cmpl_adq > owed |=> owed == 16'h0000)
    else $error("owed wrapped below zero");
  c_delay_seen: cover property (@(posedge ref_clk) disable iff (rst)
    !delayed ##1 delayed ##[1:20] req_fwd);
  c_back_to_back: cover property (@(posedge ref_clk) disable iff (rst)
    req_fwd ##2 req_fwd);
endmodule // pcixb_split_gate

module pcixb_cap_regs (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        cfg_wr_en,
  input  wire logic        cfg_rd_en,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_byte_en,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rd_ack,
  input  wire logic        up_req_valid,
  input  wire logic [15:0] up_req_adq,
  input  wire logic        up_cmpl_valid,
  input  wire logic [15:0] up_cmpl_adq,
  input  wire logic        up_delay_clr,
  output logic             up_req_fwd,
  output logic             up_delayed,
  input  wire logic        dn_req_valid,
  input  wire logic [15:0] dn_req_adq,
  input  wire logic        dn_cmpl_valid,
  input  wire logic [15:0] dn_cmpl_adq,
  input  wire logic        dn_delay_clr,
  output logic             dn_req_fwd,
  output logic             dn_delayed
);
  import pcixb_pkg::*;

  logic [15:0] up_limit;
  logic [15:0] dn_limit;
  logic [15:0] next_up_limit;
  logic [15:0] next_dn_limit;
  logic [31:0] next_rdata;
  logic        next_ack;
  logic        up_hit;
  logic        dn_hit;

  always_comb begin
    up_hit        = (cfg_addr == UP_SPLIT_OFS);
    dn_hit        = (cfg_addr == DN_SPLIT_OFS);
    next_up_limit = up_limit;
    next_dn_limit = dn_limit;
    // upstream limit write, byte lanes 2 and 3
    if (cfg_wr_en && up_hit) begin
      if (cfg_byte_en[2]) next_up_limit[7:0] = cfg_wdata[LIMIT_LSB+:8];
      if (cfg_byte_en[3]) next_up_limit[15:8] = cfg_wdata[LIMIT_LSB+8+:8];
    end
    if (cfg_wr_en && dn_hit) begin
      if (cfg_byte_en[2]) next_dn_limit[7:0] = cfg_wdata[LIMIT_LSB+:8];
      if (cfg_byte_en[3]) next_dn_limit[15:8] = cfg_wdata[LIMIT_LSB+8+:8];
    end
    // capability halves are constants; read-only words have no storage
    next_ack   = cfg_rd_en;
    next_rdata = cfg_rdata;
    if (cfg_rd_en) begin
      case (cfg_addr)
        UP_SPLIT_OFS: next_rdata = {up_limit, SPLIT_CAP_ADQ};
        DN_SPLIT_OFS: next_rdata = {dn_limit, SPLIT_CAP_ADQ};
        PM_CAP_OFS:   next_rdata = PM_CAP_WORD;
        default:      next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      up_limit   <= LIMIT_RESET;
      dn_limit   <= LIMIT_RESET;
      cfg_rdata  <= 32'h00000000;
      cfg_rd_ack <= 1'b0;
    end else begin
      up_limit   <= next_up_limit;
      dn_limit   <= next_dn_limit;
      cfg_rdata  <= next_rdata;
      cfg_rd_ack <= next_ack;
    end
  end

  pcixb_split_gate u_up (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .limit      (up_limit),
    .req_valid  (up_req_valid),
    .req_adq    (up_req_adq),
    .cmpl_valid (up_cmpl_valid),
    .cmpl_adq   (up_cmpl_adq),
    .delay_clr  (up_delay_clr),
    .req_fwd    (up_req_fwd),
    .delayed    (up_delayed)
  );

  pcixb_split_gate u_dn (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .limit      (dn_limit),
    .req_valid  (dn_req_valid),
    .req_adq    (dn_req_adq),
    .cmpl_valid (dn_cmpl_valid),
    .cmpl_adq   (dn_cmpl_adq),
    .delay_clr  (dn_delay_clr),
    .req_fwd    (dn_req_fwd),
    .delayed    (dn_delayed)
  );

  a_up_cap_fixed: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_rd_en && cfg_addr == UP_SPLIT_OFS |=> cfg_rd_ack && cfg_rdata[15:0] == 16'h0010)
    else $error("upstream capability wrong");
  a_dn_cap_fixed: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_rd_en && cfg_addr == DN_SPLIT_OFS |=> cfg_rdata[15:0] == 16'h0010)
    else $error("downstream capability wrong");
  a_up_limit_wr: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr_en && up_hit && cfg_byte_en[3:2] == 2'h3 ##1 !cfg_wr_en ##1 cfg_rd_en && up_hit
    |=> cfg_rdata[31:16] == $past(cfg_wdata[31:16], 3))
    else $error("upstream limit not written");
  a_dn_limit_wr: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr_en && dn_hit && cfg_byte_en[3:2] == 2'h3 ##1 !cfg_wr_en ##1 cfg_rd_en && dn_hit
    |=> cfg_rdata[31:16] == $past(cfg_wdata[31:16], 3))
    else $error("downstream limit not written");
  a_pm_id_next: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_rd_en && cfg_addr == PM_CAP_OFS |=> cfg_rdata[15:0] == 16'hA801)
    else $error("power header id or pointer wrong");
  a_pm_features: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_rd_en && cfg_addr == PM_CAP_OFS |=> cfg_rdata[31:16] == 16'hC842)
    else $error("power features wrong");
  a_ro_kept: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr_en && cfg_addr == PM_CAP_OFS ##2 cfg_rd_en && cfg_addr == PM_CAP_OFS
    |=> cfg_rdata == 32'hC842A801)
    else $error("read-only word changed by write");
  c_limit_max: cover property (@(posedge ref_clk) disable iff (rst)
    up_limit == 16'hFFFF && up_req_fwd);
  c_pm_read: cover property (@(posedge ref_clk) disable iff (rst)
    cfg_rd_en && cfg_addr == PM_CAP_OFS ##1 cfg_rd_ack);
  a_regs_reset: assert property (@(posedge ref_clk)
    rst |=> up_limit == 16'h0010 && dn_limit == 16'h0010 && cfg_rdata == 32'h00000000)
    else $error("register reset values wrong");
  a_ack_follows: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> cfg_rd_ack == $past(cfg_rd_en))
    else $error("read acknowledge out of step");
  a_rdata_holds: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg_rd_en |=> $stable(cfg_rdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_rd_en && !up_hit && !dn_hit && cfg_addr != PM_CAP_OFS |=> cfg_rdata == 32'h00000000)
    else $error("unmapped offset read not zero");
  a_up_low_lanes: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr_en && up_hit && cfg_byte_en[3:2] == 2'h0 |=> $stable(up_limit))
    else $error("upstream limit changed by low lanes");
  a_dn_low_lanes: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr_en && dn_hit && cfg_byte_en[3:2] == 2'h0 |=> $stable(dn_limit))
    else $error("downstream limit changed by low lanes");
  a_up_lane_two: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr_en && up_hit && cfg_byte_en[3:2] == 2'h1
    |=> up_limit == {$past(up_limit[15:8]), $past(cfg_wdata[23:16])})
    else $error("upstream limit low byte write wrong");
  a_dn_lane_three: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr_en && dn_hit && cfg_byte_en[3:2] == 2'h2
    |=> dn_limit == {$past(cfg_wdata[31:24]), $past(dn_limit[7:0])})
    else $error("downstream limit high byte write wrong");
  a_limits_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg_wr_en |=> $stable(up_limit) && $stable(dn_limit))
    else $error("limit changed without a write");
  c_limit_rewrite: cover property (@(posedge ref_clk) disable iff (rst)
    cfg_wr_en && up_hit ##2 cfg_rd_en && up_hit);
endmodule // pcixb_cap_regs

//--- sim/pcixb_cap_regs_bench.sv
// self-checking bench for the split budget and power capability registers
// assumes the top pcixb_cap_regs alone, inputs driven at the falling edge
`timescale 1ns/10ps

module pcixb_cap_regs_bench;
  import pcixb_pkg::*;
  logic             ref_clk = 1'b0;
  logic             rst = 1'b1;
  logic             cfg_wr_en = 1'b0;
  logic             cfg_rd_en = 1'b0;
  logic [7:0]       cfg_addr = 8'h00;
  logic [3:0]       cfg_byte_en = 4'h0;
  logic [31:0]      cfg_wdata = 32'h0;
  logic [31:0]      cfg_rdata;
  logic             cfg_rd_ack;
  logic [1:0]       req_valid = 2'h0;
  logic [1:0][15:0] req_adq = '0;
  logic [1:0]       cmpl_valid = 2'h0;
  logic [1:0][15:0] cmpl_adq = '0;
  logic [1:0]       clr = 2'h0;
  logic [1:0]       fwd;
  logic [1:0]       dly;
  int               bad_count = 0;
  int               checked = 0;

  always #4 ref_clk = ~ref_clk;

  pcixb_cap_regs dut (
    .ref_clk(ref_clk), .rst(rst), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
    .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rd_ack(cfg_rd_ack),
    .up_req_valid(req_valid[0]), .up_req_adq(req_adq[0]), .up_cmpl_valid(cmpl_valid[0]),
    .up_cmpl_adq(cmpl_adq[0]), .up_delay_clr(clr[0]), .up_req_fwd(fwd[0]),
    .up_delayed(dly[0]),
    .dn_req_valid(req_valid[1]), .dn_req_adq(req_adq[1]), .dn_cmpl_valid(cmpl_valid[1]),
    .dn_cmpl_adq(cmpl_adq[1]), .dn_delay_clr(clr[1]), .dn_req_fwd(fwd[1]),
    .dn_delayed(dly[1])
  );

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge ref_clk);
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_byte_en = be;
    cfg_wdata = d;
    @(negedge ref_clk);
    cfg_wr_en = 1'b0;
  endtask

  task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
    @(negedge ref_clk);
    cfg_rd_en = 1'b1;
    cfg_addr = a;
    @(negedge ref_clk);
    cfg_rd_en = 1'b0;
    check("rd_ack", 32'h1, {31'h0, cfg_rd_ack});
    check("rdata", exp, cfg_rdata);
  endtask

  // watch for a forward within n cycles; the requester drops valid once it is seen
  task automatic wait_fwd(input int d, input int n, input logic exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      @(negedge ref_clk);
      if (fwd[d] === 1'b1) begin
        seen = 1'b1;
        req_valid[d] = 1'b0;
      end
    end
    check("req_fwd", {31'h0, exp}, {31'h0, seen});
  endtask

  task automatic req(input int d, input logic [15:0] adq, input int n, input logic exp);
    @(negedge ref_clk);
    req_valid[d] = 1'b1;
    req_adq[d] = adq;
    wait_fwd(d, n, exp);
  endtask

  task automatic cmpl(input int d, input logic [15:0] adq);
    @(negedge ref_clk);
    cmpl_valid[d] = 1'b1;
    cmpl_adq[d] = adq;
    @(negedge ref_clk);
    cmpl_valid[d] = 1'b0;
  endtask

  task automatic gate_test(input int d);
    logic [7:0] a;
    a = (d == 1) ? 8'h8C : 8'h88;
    cfg_write(a, 4'hF, 32'h0010_0000);
    req(d, 16'h0010, 1, 1'b1);
    req(d, 16'h0001, 3, 1'b0);
    check("delayed", 32'h1, {31'h0, dly[d]});
    cmpl(d, 16'h0001);
    wait_fwd(d, 3, 1'b1);
    @(negedge ref_clk);
    clr[d] = 1'b1;
    @(negedge ref_clk);
    clr[d] = 1'b0;
    check("delay_clear", 32'h0, {31'h0, dly[d]});
    cmpl(d, 16'h0010);
    // a drain past zero must floor, or the next full request would be held
    cmpl(d, 16'h0001);
    req(d, 16'h0010, 1, 1'b1);
    cmpl(d, 16'h0010);
    // unbounded limit must never hold back, even with owed saturated
    cfg_write(a, 4'hC, 32'hFFFF_0000);
    req(d, 16'hFFFF, 1, 1'b1);
    req(d, 16'h0001, 1, 1'b1);
    check("no_delay", 32'h0, {31'h0, dly[d]});
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    cfg_read(8'h88, 32'h0010_0010);
    cfg_read(8'h8C, 32'h0010_0010);
    cfg_read(8'h90, 32'hC842_A801);
    cfg_read(8'hA0, 32'h0000_0000);
    cfg_write(8'h88, 4'hF, 32'hFFFF_FFFF);
    cfg_write(8'h8C, 4'hF, 32'hFFFF_FFFF);
    cfg_write(8'h90, 4'hF, 32'hFFFF_FFFF);
    cfg_read(8'h88, 32'hFFFF_0010);
    cfg_read(8'h8C, 32'hFFFF_0010);
    cfg_read(8'h90, 32'hC842_A801);
    cfg_write(8'h88, 4'h4, 32'h1234_5678);
    cfg_read(8'h88, 32'hFF34_0010);
    cfg_write(8'h8C, 4'h8, 32'h1234_5678);
    cfg_read(8'h8C, 32'h12FF_0010);
    cfg_write(8'h88, 4'h3, 32'h0000_0000);
    cfg_write(8'h8C, 4'h3, 32'h0000_0000);
    cfg_read(8'h88, 32'hFF34_0010);
    cfg_read(8'h8C, 32'h12FF_0010);
    cfg_write(8'h88, 4'hC, 32'hABCD_0000);
    cfg_read(8'h88, 32'hABCD_0010);
    cfg_write(8'h8C, 4'hC, 32'h0000_0000);
    cfg_read(8'h8C, 32'h0000_0010);
    cfg_write(8'h90, 4'hF, 32'h0000_0000);
    cfg_read(8'h90, 32'hC842_A801);
    gate_test(0);
    gate_test(1);
    print_verdict();
  end

  // the sequence needs about 110 cycles; 5000 leaves ample margin
  initial begin
    #40000;
    bad_count++;
    print_verdict();
  end
endmodule // pcixb_cap_regs_bench
